// File: gpio_regs_pkg.sv
// Package for the pin configuration register block: offsets, widths,
// field positions and reset values.
// Assumes an 8-bit register port with byte addresses from the host side.
package gpio_regs_pkg;

  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned PIN_N    = 19;
  localparam int unsigned BANK_N   = 4;
  localparam int unsigned GROUP_N  = 3;

  // Debounce bypass bank (pins 1-8, 9-16, 17-19)
  localparam logic [7:0] DEB_A_OFS  = 8'h27;
  localparam logic [7:0] DEB_B_OFS  = 8'h28;
  localparam logic [7:0] DEB_C_OFS  = 8'h29;
  // Output level bank
  localparam logic [7:0] LVL_A_OFS  = 8'h2a;
  localparam logic [7:0] LVL_B_OFS  = 8'h2b;
  localparam logic [7:0] LVL_C_OFS  = 8'h2c;
  // Drive style bank
  localparam logic [7:0] MODE_A_OFS = 8'h2d;
  localparam logic [7:0] MODE_B_OFS = 8'h2e;
  localparam logic [7:0] MODE_C_OFS = 8'h2f;
  // Direction bank
  localparam logic [7:0] DIR_A_OFS  = 8'h30;
  localparam logic [7:0] DIR_B_OFS  = 8'h31;
  localparam logic [7:0] DIR_C_OFS  = 8'h32;

  // Implemented bits of full and third registers of each group, and the reset value
  localparam logic [7:0] FULL_MASK  = 8'hff;
  localparam logic [7:0] THIRD_MASK = 8'h07;
  localparam logic [7:0] REG_RESET  = 8'h00;

endpackage : gpio_regs_pkg

// File: cfg_byte_reg.sv
// One 8-bit configuration register with a write mask.
// Assumes one-cycle write strobes synchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module cfg_byte_reg #(
  parameter logic [7:0] MASK  = 8'hff,
  parameter logic [7:0] RESET = 8'h00
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  output logic      [7:0] value
);

  // Masked bits never store, so reserved bits stay zero
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      value <= RESET & MASK;
    else if (wrEn)
      value <= wrData & MASK;
  end

endmodule : cfg_byte_reg
`default_nettype wire

// File: gpio_output_direction_debounce_regs.sv
// Pin configuration registers of a 19-pin I/O expander: debounce bypass,
// output level, drive style and direction, plus the pad controls.
// Assumes a serial host interface upstream that turns transactions into
// one-cycle register read/write strobes on mclk.
//
// Notes on behaviour
// RQ1: Bypass bits for inputs 17-19 at 0x29.
// RQ2: Output level per pin, three registers.
// RQ3: Drive style pins 1-16, one means open-drain.
// RQ4: Drive style pins 17-19 at 0x2f bits 0-2.
// RQ5: Direction per pin, one means output.
// RQ6: Bits 7-3 of third registers reserved.
// RQ7: Bypass bits for inputs 1-16 at 0x27-0x28.
// RQ8: Drive only when output; reserved read zero.
`timescale 1ns/100ps
`default_nettype none
module gpio_output_direction_debounce_regs (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  output logic             regHit,
  output logic      [18:0] general_output,
  output logic      [18:0] padOutEn_b,
  output logic      [18:0] filterBypass
);

  localparam int unsigned NREG =
    gpio_regs_pkg::BANK_N * gpio_regs_pkg::GROUP_N;

  // Register offsets in bank order; debounce, level, mode, direction
  localparam logic [7:0] OFS [0:11] = '{
    gpio_regs_pkg::DEB_A_OFS,  gpio_regs_pkg::DEB_B_OFS,
    gpio_regs_pkg::DEB_C_OFS,  gpio_regs_pkg::LVL_A_OFS,
    gpio_regs_pkg::LVL_B_OFS,  gpio_regs_pkg::LVL_C_OFS,
    gpio_regs_pkg::MODE_A_OFS, gpio_regs_pkg::MODE_B_OFS,
    gpio_regs_pkg::MODE_C_OFS, gpio_regs_pkg::DIR_A_OFS,
    gpio_regs_pkg::DIR_B_OFS,  gpio_regs_pkg::DIR_C_OFS};

  logic [7:0]  regVal [0:11];
  logic [11:0] sel;
  logic [7:0]  next_rdData;
  logic [23:0] debBits;
  logic [23:0] lvlBits;
  logic [23:0] modeBits;
  logic [23:0] dirBits;
  logic [18:0] drivenHigh;

  // One register per offset; third of each group keeps three bits only
  genvar g;
  generate
    for (g = 0; g < NREG; g++)
    begin : gReg
      assign sel[g] = (regAddr == OFS[g]);
      cfg_byte_reg #(
        .MASK  ((g % 3 == 2) ? gpio_regs_pkg::THIRD_MASK
                             : gpio_regs_pkg::FULL_MASK), // RQ6
        .RESET (gpio_regs_pkg::REG_RESET)
      ) uReg (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .wrEn   (regWrite && sel[g]),
        .wrData (regWrData),
        .value  (regVal[g])
      );
    end
  endgenerate

  // Read mux; unmapped addresses return zero
  always_comb
  begin
    next_rdData = 8'h00;
    for (int i = 0; i < NREG; i++)
      if (sel[i])
        next_rdData = regVal[i]; // RQ8
  end

  assign regHit = |sel;

  // Read data is registered, valid the cycle after regRead
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      regRdData <= 8'h00;
    else if (regRead)
      regRdData <= next_rdData;
  end

  // Pin n sits at bit (n-1) mod 8 of the group's register
  assign debBits  = {regVal[2],  regVal[1],  regVal[0]};  // RQ1 RQ7
  assign lvlBits  = {regVal[5],  regVal[4],  regVal[3]};  // RQ2
  assign modeBits = {regVal[8],  regVal[7],  regVal[6]};  // RQ3 RQ4
  assign dirBits  = {regVal[11], regVal[10], regVal[9]};  // RQ5

  assign filterBypass = debBits[18:0]; // RQ1 RQ7

  // Open-drain never drives high; input pins never drive at all
  assign drivenHigh = lvlBits[18:0] & ~modeBits[18:0];
  assign general_output = lvlBits[18:0] & dirBits[18:0]; // RQ8
  assign padOutEn_b = ~(dirBits[18:0]
                        & (drivenHigh | ~lvlBits[18:0])); // RQ3 RQ8

  // Host strobes aimed at one register: the strobe is the first step,
  // its effect on the stored bits one cycle later the second
  sequence wrDebA_s;
    regWrite && regAddr == gpio_regs_pkg::DEB_A_OFS;
  endsequence
  sequence wrDebB_s;
    regWrite && regAddr == gpio_regs_pkg::DEB_B_OFS;
  endsequence
  sequence wrDebC_s;
    regWrite && regAddr == gpio_regs_pkg::DEB_C_OFS;
  endsequence
  sequence wrLvlA_s;
    regWrite && regAddr == gpio_regs_pkg::LVL_A_OFS;
  endsequence
  sequence wrLvlB_s;
    regWrite && regAddr == gpio_regs_pkg::LVL_B_OFS;
  endsequence
  sequence wrLvlC_s;
    regWrite && regAddr == gpio_regs_pkg::LVL_C_OFS;
  endsequence
  sequence wrModeA_s;
    regWrite && regAddr == gpio_regs_pkg::MODE_A_OFS;
  endsequence
  sequence wrModeB_s;
    regWrite && regAddr == gpio_regs_pkg::MODE_B_OFS;
  endsequence
  sequence wrModeC_s;
    regWrite && regAddr == gpio_regs_pkg::MODE_C_OFS;
  endsequence
  sequence wrDirA_s;
    regWrite && regAddr == gpio_regs_pkg::DIR_A_OFS;
  endsequence
  sequence wrDirB_s;
    regWrite && regAddr == gpio_regs_pkg::DIR_B_OFS;
  endsequence
  sequence wrDirC_s;
    regWrite && regAddr == gpio_regs_pkg::DIR_C_OFS;
  endsequence
  // A read alone; a write in the same cycle would blur the expectation
  sequence rdModeA_s;
    regRead && regAddr == gpio_regs_pkg::MODE_A_OFS && !regWrite;
  endsequence

  // Push-pull output pins always drive their pad
  outEnRule_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ3
    (dirBits[18:0] & ~modeBits[18:0] & padOutEn_b) == 19'h00000)
    else $error("push-pull output not driven");
  // An output set low drives its pad in either drive style
  lowDrive_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ8
    (dirBits[18:0] & ~lvlBits[18:0] & padOutEn_b) == 19'h00000)
    else $error("low output not driven");

  // A write to a direction register shows in the direction bits next cycle
  dirWrite_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ5
    wrDirA_s |=> dirBits[7:0] == $past(regWrData))
    else $error("direction 1-8 write lost");
  dirMid_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ5
    wrDirB_s |=> dirBits[15:8] == $past(regWrData))
    else $error("direction 9-16 write lost");
  dirTop_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ5
    wrDirC_s |=> dirBits[18:16] == $past(regWrData[2:0]))
    else $error("direction 17-19 write lost");

  // Reserved bits of the third registers stay zero
  resvZero_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ6
    regVal[2][7:3] == 5'h00 && regVal[5][7:3] == 5'h00
    && regVal[8][7:3] == 5'h00 && regVal[11][7:3] == 5'h00)
    else $error("reserved bits set");

  // Each bypass register lands on its own group of input filters
  bypassLow_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ7
    wrDebA_s |=> filterBypass[7:0] == $past(regWrData))
    else $error("bypass 1-8 write lost");
  bypassMid_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ7
    wrDebB_s |=> filterBypass[15:8] == $past(regWrData))
    else $error("bypass 9-16 write lost");
  bypassWr_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ1
    wrDebC_s |=> filterBypass[18:16] == $past(regWrData[2:0]))
    else $error("bypass 17-19 write lost");

  // Level writes land in the level bits of their pins
  levelLow_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ2
    wrLvlA_s |=> lvlBits[7:0] == $past(regWrData))
    else $error("level 1-8 write lost");
  levelWr_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ2
    wrLvlB_s |=> lvlBits[15:8] == $past(regWrData))
    else $error("level 9-16 write lost");
  levelTop_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ2
    wrLvlC_s |=> lvlBits[18:16] == $past(regWrData[2:0]))
    else $error("level 17-19 write lost");

  // Drive style writes land in the style bits of their pins
  modeLow_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ3
    wrModeA_s |=> modeBits[7:0] == $past(regWrData))
    else $error("style 1-8 write lost");
  modeMid_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ3
    wrModeB_s |=> modeBits[15:8] == $past(regWrData))
    else $error("style 9-16 write lost");
  modeTop_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ4
    wrModeC_s |=> modeBits[18:16] == $past(regWrData[2:0]))
    else $error("style 17-19 write lost");

  // Input pins never drive and show no output level
  inputQuiet_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ8
    (padOutEn_b | dirBits[18:0]) == 19'h7ffff)
    else $error("input pin driven");
  levelMask_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ8
    (general_output & ~dirBits[18:0]) == 19'h00000)
    else $error("input pin shows a level");
  // Open-drain high releases the pad of pins 17-19
  odRelease_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ4
    (modeBits[18:16] & lvlBits[18:16] & ~padOutEn_b[18:16]) == 3'h0)
    else $error("open-drain drives high");

  // Readback of a mode register one cycle after the read
  modeRead_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ3
    rdModeA_s |=> regRdData == modeBits[7:0])
    else $error("mode readback wrong");
  // A read of an unmapped address returns zero
  unmapRead_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ8
    regRead && !regHit |=> regRdData == 8'h00)
    else $error("unmapped read not zero");

endmodule : gpio_output_direction_debounce_regs
`default_nettype wire

// File: host_model.sv
// Host side: turns register accesses into one-cycle strobes.
// Assumes tb_top supplies mclk; strobes change at the falling edge.
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic       mclk,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData
);
  // Quiet bus at time zero
  initial
  begin
    regWrite  = 1'b0;
    regRead   = 1'b0;
    regAddr   = 8'h00;
    regWrData = 8'h00;
  end

  // One access, then an idle cycle; stale data is scrambled on release
  task automatic access(input logic wr, input logic [7:0] a, d);
  begin
    @(negedge mclk);
    regWrite  = wr;
    regRead   = !wr;
    regAddr   = a;
    regWrData = d;
    @(negedge mclk);
    regWrite  = 1'b0;
    regRead   = 1'b0;
    regWrData = ~d;
  end
  endtask : access
endmodule : host_model
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the pin configuration registers.
// Assumes a single mclk domain and a mirror of all twelve registers.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        mclk, rst_b, regWrite, regRead, regHit;
  logic [7:0]  regAddr, regWrData, regRdData, a, d;
  logic [18:0] general_output, padOutEn_b, filterBypass;
  logic [23:0] deb, lvl, mode, dir;
  logic [18:0] enExp;
  logic [7:0]  m [12];
  logic [7:0]  expQ [$];
  logic [31:0] r;
  integer      seed, n_fail, comparisons, i;

  host_model host (.mclk(mclk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData));
  gpio_output_direction_debounce_regs uut (.mclk(mclk), .rst_b(rst_b),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regHit(regHit),
    .general_output(general_output), .padOutEn_b(padOutEn_b),
    .filterBypass(filterBypass));

  assign deb  = {m[2], m[1], m[0]};
  assign lvl  = {m[5], m[4], m[3]};
  assign mode = {m[8], m[7], m[6]};
  assign dir  = {m[11], m[10], m[9]};
  // Pad enable low only for an output that is not open-drain high
  assign enExp = ~(dir[18:0] & ~(mode[18:0] & lvl[18:0]));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // One compare task per kind of result: pin controls, read data, decode
  task automatic cmpPin(input string nm, input logic [18:0] e, g);
  begin
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  end
  endtask : cmpPin

  task automatic cmpRead(input logic [7:0] e, g);
  begin
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value read data expected %h seen %h", e, g);
    end
  end
  endtask : cmpRead

  task automatic cmpHit(input logic e, g);
  begin
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value address hit expected %b seen %b", e, g);
    end
  end
  endtask : cmpHit

  // Read data appears one cycle after the strobe
  always @(posedge mclk)
    if (regRead === 1'b1)
    begin
      @(negedge mclk);
      cmpRead(expQ.pop_front(), regRdData);
    end

  // The address stays up after release, so the decode is checked then
  task automatic rd(input logic [7:0] ra, e);
  begin
    expQ.push_back(e);
    host.access(1'b0, ra, 8'h00);
    cmpHit(ra >= 8'h27 && ra <= 8'h32, regHit);
  end
  endtask : rd

  // Pad controls against the mirror of the registers
  task automatic chkPins();
  begin
    cmpPin("bypass", deb[18:0], filterBypass);
    cmpPin("level", lvl[18:0] & dir[18:0], general_output);
    cmpPin("enable", enExp, padOutEn_b);
  end
  endtask : chkPins

  task automatic results();
  begin
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask : results

  // Watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    #100000;
    n_fail++;
    results();
  end

  initial
  begin
    seed = 32'h6008f573;
    n_fail = 0;
    comparisons = 0;
    foreach (m[k]) m[k] = 8'h00;
    rst_b = 1'b0;
    repeat (10) @(posedge mclk);
    @(negedge mclk) rst_b = 1'b1;
    // Reset values, plus unmapped neighbours on both sides
    for (i = 8'h26; i <= 8'h33; i++)
      rd(i[7:0], 8'h00);
    // Random writes with readback and pad checks
    // The first twelve passes visit every register once, the rest random
    for (i = 0; i < 40; i++)
    begin
      r = $random(seed);
      a = (i < 12) ? 8'h27 + 8'(i) : 8'h27 + 8'(r[15:0] % 16'd12);
      d = r[31:24];
      host.access(1'b1, a, d);
      m[a - 8'h27] = d & ((a - 8'h27) % 3 == 2 ? 8'h07 : 8'hff);
      rd(a, m[a - 8'h27]);
      chkPins();
    end
    // Reset in mid-run clears every register and releases every pad
    @(negedge mclk) rst_b = 1'b0;
    foreach (m[k]) m[k] = 8'h00;
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    chkPins();
    for (i = 8'h27; i <= 8'h32; i++)
      rd(i[7:0], 8'h00);
    // Unmapped write is ignored
    host.access(1'b1, 8'h33, 8'hff);
    rd(8'h33, 8'h00);
    repeat (2) @(negedge mclk);
    results();
  end
endmodule : tb_top
`default_nettype wire
